// *** bench/dwrc_ctl_model.sv ***
// memory controller model: commands and write beats
`timescale 1ns/1ps
module dwrc_ctl_model (
  input wire logic clk,
  input wire logic mem_ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [15:0] addr,
  output logic [15:0] dq_in,
  output logic [1:0] dm_in,
  output logic dq_valid,
  input wire logic beat_ready
);
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 3'h0;
    addr = 16'h0000;
    dq_in = 16'h0000;
    dm_in = 2'h0;
    dq_valid = 1'b0;
  end
  // refresh debt: one owed per interval, one paid per refresh until eight are paid ahead; interval is a bench choice
  localparam int REFI_NS = 6400;
  int ref_debt = 0;
  always #(REFI_NS) ref_debt = ref_debt + 1;
  // held a whole ck period around the rise; then deselect only
  task cmd(input logic [3:0] c, input logic [15:0] a, input logic [2:0] b);
    @(negedge mem_ck);
    @(posedge clk) #1;
    {cs_n, ras_n, cas_n, we_n} = c;
    addr = a;
    ba = b;
    if (c == 4'h1 && ref_debt > -8) begin
      ref_debt = ref_debt - 1;
    end
    @(negedge mem_ck);
    @(posedge clk) #1;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    addr = ~addr;
    ba = ~ba;
  endtask : cmd
  // beats after write latency; mask moves with its data
  task beats(input int n, input logic [15:0] d, input logic [1:0] m);
    repeat (5) @(posedge mem_ck);
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < n; i++) begin
      dq_valid = 1'b1;
      dq_in = d + 16'(i);
      dm_in = m;
      do @(negedge clk); while (beat_ready !== 1'b1);
      @(posedge clk) #1;
    end
    dq_valid = 1'b0;
    dq_in = ~dq_in;
  endtask : beats
endmodule : dwrc_ctl_model

// *** bench/dwrc_sva.sv ***
// port assertions for the ddr3 write and refresh block
`timescale 1ns/1ps
module dwrc_sva #(
  parameter int DQ_W = 16,
  parameter int TRFC_CYC = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mem_ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [15:0] addr,
  input wire logic [1:0] mode_burst,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [DQ_W-1:0] wr_data,
  input wire logic [DQ_W/8-1:0] wr_byte_en,
  input wire logic ref_busy,
  input wire logic [12:0] ref_row,
  input wire logic banks_idle,
  input wire logic [3:0] burst_beats
);
  logic [2:0] ck_q;
  logic [3:0] rise_cnt_q;
  logic rise, take, wr_cmd, rf_cmd;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // own three-stage look at the link clock, same as the core
  always_ff @(posedge clk) begin
    if (sys_rst) ck_q <= 3'h0;
    else ck_q <= {ck_q[1:0], mem_ck};
  end
  assign rise = ck_q[1] & ~ck_q[2];
  assign take = rise & banks_idle & ~ref_busy;
  assign wr_cmd = take & ({cs_n, ras_n, cas_n, we_n} == 4'h4);
  assign rf_cmd = take & ({cs_n, ras_n, cas_n, we_n} == 4'h1);
  // link rises seen during one refresh
  always_ff @(posedge clk) begin
    if (sys_rst || !ref_busy) rise_cnt_q <= 4'h0;
    else if (rise) rise_cnt_q <= rise_cnt_q + 4'h1;
  end
  a_ref_decode: assert property (rf_cmd |=> ref_busy)
    else $error("refresh not started");
  a_ref_idle: assert property ($fell(ref_busy) |-> ##[0:1] banks_idle)
    else $error("banks not idle after refresh");
  a_row_quiet: assert property (!ref_busy && !$past(ref_busy) |-> $stable(ref_row))
    else $error("row counter moved outside refresh");
  a_ref_span: assert property (ref_busy |-> rise_cnt_q <= TRFC_CYC)
    else $error("refresh too long");
  a_beats_legal: assert property (burst_beats == 4'h4 || burst_beats == 4'h8)
    else $error("illegal burst length");
  a_fixed_chop: assert property (wr_cmd && mode_burst == 2'h2 |-> ##[1:100] burst_beats == 4'h4)
    else $error("fixed chop not four");
  a_fixed_eight: assert property (wr_cmd && mode_burst == 2'h0 |-> ##[1:100] burst_beats == 4'h8)
    else $error("fixed eight not eight");
  a_otf_chop: assert property (wr_cmd && mode_burst == 2'h1 && !addr[12]
    |-> ##[1:100] burst_beats == 4'h4)
    else $error("chop on the fly not four");
  a_otf_eight: assert property (wr_cmd && mode_burst == 2'h1 && addr[12]
    |-> ##[1:100] burst_beats == 4'h8)
    else $error("eight on the fly not eight");
  a_out_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_data, wr_byte_en}))
    else $error("beat changed while stalled");
  a_burst_ends: assert property (wr_cmd |-> ##[1:100] banks_idle)
    else $error("write burst never closed");
endmodule : dwrc_sva
bind dwrc_core dwrc_sva #(.DQ_W(DQ_W), .TRFC_CYC(TRFC_CYC)) sva_u (.*);

// *** bench/tb.sv ***
// bench: reset, refresh, write bursts and a masked read
`timescale 1ns/1ps
module tb;
  logic clk = 0, sys_rst = 1, mem_ck = 0, wr_ready = 0;
  logic cs_n, ras_n, cas_n, we_n, dq_valid, beat_ready, wr_valid, ref_busy, banks_idle;
  logic [2:0] ba, wr_bank;
  logic [15:0] addr, dq_in, wr_data;
  logic [1:0] mode_burst = 2'h0, dm_in, wr_byte_en;
  logic [12:0] wr_col, ref_row;
  logic [3:0] burst_beats;
  int mismatches = 0, samples_checked = 0;
  dwrc_core #(.TRFC_CYC(4)) dut_u (.*);
  dwrc_ctl_model ctl_u (.*);
  // clocks; link clock offset so phases never line up
  always #20 clk = ~clk;
  initial begin
    #7;
    forever #160 mem_ck = ~mem_ck;
  end
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wrap_up;
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task t_reset;
    chk("banks_idle", 1, banks_idle);
    chk("ref_busy", 0, ref_busy);
    chk("wr_valid", 0, wr_valid);
    chk("burst_beats", 8, burst_beats);
    chk("ref_row", 0, ref_row);
  endtask : t_reset
  // address pins full of ones must not steer the row
  task t_refresh;
    for (int i = 1; i <= 2; i++) begin
      ctl_u.cmd(4'h1, 16'hFFFF, 3'h7);
      repeat (4) @(posedge clk);
      #1;
      chk("ref_busy", 1, ref_busy);
      repeat (40) @(posedge clk);
      #1;
      chk("ref_row", 16'(i), ref_row);
      chk("banks_idle", 1, banks_idle);
    end
  endtask : t_refresh
  // fifo stalled through the burst, then drained
  task t_write(input logic [1:0] md, input logic [15:0] a, input int n, input logic [1:0] m);
    @(posedge clk) #1;
    mode_burst = md;
    ctl_u.cmd(4'h4, a, a[6:4]);
    ctl_u.beats(n, ~a, m);
    repeat (2) @(negedge clk);
    chk("burst_beats", 16'(n), burst_beats);
    chk("beat_ready", 16'(n != 8), beat_ready);
    @(posedge clk) #1;
    wr_ready = 1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      chk("wr_valid", 1, wr_valid);
      chk("wr_data", ~a + 16'(i), wr_data);
      chk("wr_byte_en", {14'h0000, ~m}, wr_byte_en);
      chk("wr_col", 16'(a[9:0]) + 16'(i), wr_col);
      chk("wr_bank", {13'h0000, a[6:4]}, wr_bank);
    end
    @(posedge clk) #1;
    wr_ready = 0;
    chk("wr_valid", 0, wr_valid);
  endtask : t_write
  // eight-beat write cut after three beats: device closes it alone, keeps what came
  task t_short;
    @(posedge clk) #1;
    mode_burst = 2'h0;
    ctl_u.cmd(4'h4, 16'h0050, 3'h5);
    ctl_u.beats(3, 16'h1234, 2'h0);
    repeat (80) @(posedge clk);
    #1;
    chk("banks_idle", 1, banks_idle);
    chk("wr_valid", 1, wr_valid);
    chk("wr_data", 16'h1234, wr_data);
    chk("wr_bank", 16'h0005, wr_bank);
    wr_ready = 1;
    repeat (3) @(posedge clk);
    #1;
    wr_ready = 0;
    chk("wr_valid", 0, wr_valid);
  endtask : t_short
  task t_read;
    ctl_u.cmd(4'h5, 16'h1000, 3'h0);
    ctl_u.beats(4, 16'hBEEF, 2'h3);
    repeat (4) @(posedge clk);
    chk("wr_valid", 0, wr_valid);
  endtask : t_read
  initial begin
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 0;
    t_reset;
    t_refresh;
    t_write(2'h2, 16'h1010, 4, 2'h1);
    t_write(2'h0, 16'h0020, 8, 2'h2);
    t_write(2'h1, 16'h1030, 8, 2'h0);
    t_write(2'h1, 16'h0040, 4, 2'h3);
    t_short;
    t_read;
    wrap_up;
  end
  // watchdog well past the expected run length
  initial begin
    #400000;
    mismatches++;
    wrap_up;
  end
endmodule : tb

// *** include/dwrc_cfg.svh ***
// timing, field and width constants for the ddr3 write and refresh block
`ifndef DWRC_CFG_SVH
`define DWRC_CFG_SVH
`define DWRC_BURST_OTF_BIT 12
`define DWRC_MR_BL_FIXED8 2'h0
`define DWRC_MR_BL_OTF 2'h1
`define DWRC_MR_BL_FIXED4 2'h2
`define DWRC_BEATS_BL8 4'h8
`define DWRC_BEATS_BC4 4'h4
`define DWRC_BEAT_RATE_SHIFT 1
`define DWRC_CWL_CYCLES 4'h5
`define DWRC_TRFC_NS 160
`define DWRC_CLK_NS 40
`define DWRC_TRFC_CYC ((`DWRC_TRFC_NS + `DWRC_CLK_NS - 1) / `DWRC_CLK_NS)
`define DWRC_ROW_W 13
`define DWRC_COL_W 10
`define DWRC_BANK_W 3
`endif

// *** include/dwrc_pkg.sv ***
// types of the ddr3 write and refresh block
package dwrc_pkg;
  typedef enum logic [2:0] {
    DWRC_CMD_OTHER = 3'h0,
    DWRC_CMD_WRITE = 3'h1,
    DWRC_CMD_READ = 3'h2,
    DWRC_CMD_REFRESH = 3'h3
  } dwrc_cmd_type;
  typedef enum logic [1:0] {
    DWRC_ST_IDLE = 2'h0,
    DWRC_ST_WAIT = 2'h1,
    DWRC_ST_BURST = 2'h2,
    DWRC_ST_REFRESH = 2'h3
  } dwrc_state_type;
endpackage : dwrc_pkg

// *** verilog/dwrc_core.sv ***
// ddr3 device side: write bursts with masking, refresh decode and row counter
`timescale 1ns/1ps
`include "dwrc_cfg.svh"
module dwrc_core #(
  parameter int DQ_W = 16,
  parameter int FIFO_DEPTH = 8,
  parameter int TRFC_CYC = `DWRC_TRFC_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mem_ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`DWRC_BANK_W-1:0] ba,
  input wire logic [15:0] addr,
  input wire logic [1:0] mode_burst,
  input wire logic [DQ_W-1:0] dq_in,
  input wire logic [DQ_W/8-1:0] dm_in,
  input wire logic dq_valid,
  output logic beat_ready,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [`DWRC_BANK_W-1:0] wr_bank,
  output logic [`DWRC_ROW_W-1:0] wr_col,
  output logic [DQ_W-1:0] wr_data,
  output logic [DQ_W/8-1:0] wr_byte_en,
  output logic ref_busy,
  output logic [`DWRC_ROW_W-1:0] ref_row,
  output logic banks_idle,
  output logic [3:0] burst_beats
);
  localparam int NB = DQ_W / 8;
  localparam int FW = DQ_W + NB + `DWRC_BANK_W + `DWRC_COL_W;

  logic ck_s1_q, ck_s2_q, ck_s3_q;
  logic ck_rise;
  dwrc_pkg::dwrc_cmd_type cmd;
  dwrc_pkg::dwrc_state_type state_q;
  logic [3:0] wait_q;
  logic [3:0] beats_q;
  logic [3:0] beat_cnt_q;
  logic [`DWRC_BANK_W-1:0] bank_q;
  logic [`DWRC_COL_W-1:0] col_q;
  logic [7:0] rfc_q;
  logic [`DWRC_ROW_W-1:0] row_ctr_q;
  logic [3:0] cmd_beats;
  logic f_in_valid;
  logic f_in_ready;
  logic [FW-1:0] f_in_data;
  logic [FW-1:0] f_out_data;
  logic [DQ_W/8-1:0] f_mask;

  // pin clock through three flops; an edge counts when stage two is high and stage three is still low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
    end else begin
      ck_s1_q <= mem_ck;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
    end
  end
  assign ck_rise = ck_s2_q && !ck_s3_q;

  // command decode at each link rising edge; pins assumed stable around it
  always_comb begin
    cmd = dwrc_pkg::DWRC_CMD_OTHER;
    if (!cs_n && ras_n && !cas_n && !we_n) begin
      cmd = dwrc_pkg::DWRC_CMD_WRITE;
    end else if (!cs_n && ras_n && !cas_n && we_n) begin
      cmd = dwrc_pkg::DWRC_CMD_READ;
    end else if (!cs_n && !ras_n && !cas_n && we_n) begin
      cmd = dwrc_pkg::DWRC_CMD_REFRESH;
    end
  end

  // burst length from mode field and the on-the-fly bit
  always_comb begin
    case (mode_burst)
      `DWRC_MR_BL_FIXED4: cmd_beats = `DWRC_BEATS_BC4;
      `DWRC_MR_BL_OTF: cmd_beats = addr[`DWRC_BURST_OTF_BIT] ? `DWRC_BEATS_BL8
                                                            : `DWRC_BEATS_BC4;
      default: cmd_beats = `DWRC_BEATS_BL8;
    endcase
  end

  // write, wait for write latency, take beats, then back to idle
  // a mistimed beat only harms this burst's own location, never the state machine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= dwrc_pkg::DWRC_ST_IDLE;
      wait_q <= 4'h0;
      beats_q <= `DWRC_BEATS_BL8;
      bank_q <= '0;
      col_q <= '0;
      rfc_q <= 8'h00;
    end else begin
      case (state_q)
        dwrc_pkg::DWRC_ST_IDLE: begin
          if (ck_rise && cmd == dwrc_pkg::DWRC_CMD_WRITE) begin
            state_q <= dwrc_pkg::DWRC_ST_WAIT;
            wait_q <= `DWRC_CWL_CYCLES;
            beats_q <= cmd_beats;
            bank_q <= ba;
            col_q <= addr[`DWRC_COL_W-1:0];
          end else if (ck_rise && cmd == dwrc_pkg::DWRC_CMD_REFRESH) begin
            state_q <= dwrc_pkg::DWRC_ST_REFRESH;
            rfc_q <= 8'(TRFC_CYC);
          end
        end
        dwrc_pkg::DWRC_ST_WAIT: begin
          if (ck_rise) begin
            if (wait_q == 4'h1) begin
              state_q <= dwrc_pkg::DWRC_ST_BURST;
            end
            wait_q <= wait_q - 4'h1;
          end
        end
        dwrc_pkg::DWRC_ST_BURST: begin
          // the burst also closes after its own span of link cycles,
          // so missing or mistimed beats can never hang the device
          if (beat_cnt_q >= beats_q) begin
            state_q <= dwrc_pkg::DWRC_ST_IDLE;
          end else if (ck_rise) begin
            if (wait_q >= (beats_q >> `DWRC_BEAT_RATE_SHIFT) - 4'h1) begin
              state_q <= dwrc_pkg::DWRC_ST_IDLE;
            end
            wait_q <= wait_q + 4'h1;
          end
        end
        dwrc_pkg::DWRC_ST_REFRESH: begin
          if (ck_rise) begin
            if (rfc_q <= 8'h01) begin
              state_q <= dwrc_pkg::DWRC_ST_IDLE;
            end
            rfc_q <= rfc_q - 8'h01;
          end
        end
        default: state_q <= dwrc_pkg::DWRC_ST_IDLE;
      endcase
    end
  end

  // beat counter of the current burst
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      beat_cnt_q <= 4'h0;
    end else if (state_q != dwrc_pkg::DWRC_ST_BURST) begin
      beat_cnt_q <= 4'h0;
    end else if (f_in_valid && f_in_ready) begin
      beat_cnt_q <= beat_cnt_q + 4'h1;
    end
  end

  // internal refresh row counter; address pins play no part
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      row_ctr_q <= '0;
    end else if (state_q == dwrc_pkg::DWRC_ST_IDLE && ck_rise
                 && cmd == dwrc_pkg::DWRC_CMD_REFRESH) begin
      row_ctr_q <= row_ctr_q + 1'b1;
    end
  end

  // mask and data captured together only inside a write burst
  assign f_in_valid = dq_valid && state_q == dwrc_pkg::DWRC_ST_BURST
                      && beat_cnt_q < beats_q;
  assign beat_ready = f_in_ready;
  assign f_in_data = {bank_q, col_q + `DWRC_COL_W'(beat_cnt_q), dm_in, dq_in};

  dwrc_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(f_out_data)
  );

  // set mask bit blocks its byte
  assign f_mask = f_out_data[DQ_W +: NB];
  assign wr_byte_en = ~f_mask;
  assign wr_data = f_out_data[DQ_W-1:0];
  assign wr_col = `DWRC_ROW_W'(f_out_data[DQ_W+NB +: `DWRC_COL_W]);
  assign wr_bank = f_out_data[FW-1 -: `DWRC_BANK_W];

  // status
  assign ref_busy = state_q == dwrc_pkg::DWRC_ST_REFRESH;
  assign ref_row = row_ctr_q;
  assign banks_idle = state_q == dwrc_pkg::DWRC_ST_IDLE;
  assign burst_beats = beats_q;
endmodule : dwrc_core

// *** verilog/dwrc_fifo.sv ***
// small flip-flop fifo for write beats
`timescale 1ns/1ps
module dwrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // handshake terms, full and empty straight from the count
  assign in_ready = cnt_q < (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dwrc_fifo
